// ==== inc/pmdb_consts.svh ====
`ifndef PMDB_CONSTS_SVH
`define PMDB_CONSTS_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define PMDB_OFF_DIS2      12'h000
`define PMDB_OFF_DIS3      12'h004

// ----------------------------------------------------------------
// field positions and masks
// ----------------------------------------------------------------
`define PMDB_DIS2_MASK     16'hFFFF
`define PMDB_DIS3_MASK     16'hF003
`define PMDB_BIT_OC1       0
`define PMDB_BIT_OC2       1
`define PMDB_BIT_OC3       2
`define PMDB_BIT_OC4       3
`define PMDB_BIT_ADC2      0
`define PMDB_BIT_IIC2      1
`define PMDB_BIT_T6        12
`define PMDB_BIT_T7        13
`define PMDB_BIT_T8        14
`define PMDB_BIT_T9        15

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PMDB_RST_DIS2      16'h0000
`define PMDB_RST_DIS3      16'h0000

`endif

// ==== inc/pmdb_pkg.sv ====
package pmdb_pkg;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } pmdb_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } pmdb_apb_rsp_t;

  typedef struct packed {
    logic outCompare1Off;
    logic outCompare2Off;
    logic outCompare3Off;
    logic outCompare4Off;
    logic timerSixOff;
    logic timerSevenOff;
    logic timerEightOff;
    logic timerNineOff;
    logic secondIicOff;
    logic secondAdcOff;
  } pmdb_off_t;

endpackage

// ==== rtl/pmdb_gate.sv ====
// ----------------------------------------------------------------
// per-peripheral clock gate and held reset
// ----------------------------------------------------------------
module pmdb_gate (
  input  wire logic mclk,
  input  wire logic reset_n,
  input  wire logic offReq,
  output logic      clkEn,
  output logic      periphRst_n
);
  logic offR_r;

  // latch the off request so the gated clock enable changes on an edge
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      offR_r <= 1'b0;
    end else begin
      offR_r <= offReq;
    end
  end

  assign clkEn       = ~offR_r;
  assign periphRst_n = ~offR_r;

  AST_GATE_FOLLOW: assert property (@(posedge mclk) disable iff (!reset_n)
    offReq |=> (!clkEn && !periphRst_n))
    else $error("gate did not stop a disabled peripheral");
endmodule // pmdb_gate

// ==== rtl/pmdb_bank.sv ====
// Behaviour
// - second register bit 3 disables output compare 4 when 1.
// - second register bit 2 disables output compare 3 when 1.
// - second register bit 1 disables output compare 2 when 1.
// - second register bit 0 disables output compare 1 when 1.
// - third register bits 15..12 disable timers 9, 8, 7, 6.
// - third register bits 11..2 ignore writes and read zero.
// - third register bit 1 disables the second iic unit.
// - third register bit 0 disables the second adc.
//
// Register access over APB and the register offsets are this design's own decisions.
`include "pmdb_consts.svh"

module pmdb_bank (
  input  wire logic                   mclk,
  input  wire logic                   reset_n,
  input  wire pmdb_pkg::pmdb_apb_req_t apbReq,
  output pmdb_pkg::pmdb_apb_rsp_t     apbRsp,
  output pmdb_pkg::pmdb_off_t         offState,
  output logic [9:0]                  periphClkEn,
  output logic [9:0]                  periphRst_n
);
  import pmdb_pkg::*;

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [15:0] disTwo_r;
  logic [15:0] disTwo_nxt;
  logic [15:0] disThree_r;
  logic [15:0] disThree_nxt;
  logic [31:0] rdData_r;
  logic [31:0] rdData_nxt;
  logic        err_r;
  logic        err_nxt;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire setupPh   = apbReq.psel & ~apbReq.penable;
  wire hitTwo    = apbReq.paddr == `PMDB_OFF_DIS2;
  wire hitThree  = apbReq.paddr == `PMDB_OFF_DIS3;
  wire mapped    = hitTwo | hitThree;
  wire accessPh  = apbReq.psel & apbReq.penable;
  wire wrTwo     = accessPh & apbReq.pwrite & hitTwo;
  wire wrThree   = accessPh & apbReq.pwrite & hitThree;

  // read data is prepared in setup, so the slave answers with no wait state
  assign rdData_nxt = setupPh ? (hitTwo   ? {16'h0000, disTwo_r}   :
                                 hitThree ? {16'h0000, disThree_r} : 32'h00000000)
                              : rdData_r;
  assign err_nxt    = setupPh ? ~mapped : err_r;
  assign disTwo_nxt = wrTwo ? (apbReq.pwdata[15:0] & `PMDB_DIS2_MASK) : disTwo_r;
  // unimplemented bits are masked on write, so they read zero
  assign disThree_nxt = wrThree ? (apbReq.pwdata[15:0] & `PMDB_DIS3_MASK) : disThree_r;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      disTwo_r   <= `PMDB_RST_DIS2;
      disThree_r <= `PMDB_RST_DIS3;
      rdData_r   <= 32'h00000000;
      err_r      <= 1'b0;
    end else begin
      disTwo_r   <= disTwo_nxt;
      disThree_r <= disThree_nxt;
      rdData_r   <= rdData_nxt;
      err_r      <= err_nxt;
    end
  end

  assign apbRsp.pready  = 1'b1;
  assign apbRsp.pslverr = accessPh & err_r;
  assign apbRsp.prdata  = rdData_r;

  // ----------------------------------------------------------------
  // disable fields
  // ----------------------------------------------------------------
  assign offState.outCompare4Off = disTwo_r[`PMDB_BIT_OC4];
  assign offState.outCompare3Off = disTwo_r[`PMDB_BIT_OC3];
  assign offState.outCompare2Off = disTwo_r[`PMDB_BIT_OC2];
  assign offState.outCompare1Off = disTwo_r[`PMDB_BIT_OC1];
  assign offState.timerNineOff   = disThree_r[`PMDB_BIT_T9];
  assign offState.timerEightOff  = disThree_r[`PMDB_BIT_T8];
  assign offState.timerSevenOff  = disThree_r[`PMDB_BIT_T7];
  assign offState.timerSixOff    = disThree_r[`PMDB_BIT_T6];
  assign offState.secondIicOff   = disThree_r[`PMDB_BIT_IIC2];
  assign offState.secondAdcOff   = disThree_r[`PMDB_BIT_ADC2];

  // ----------------------------------------------------------------
  // per-peripheral gates, index follows the struct order from msb
  // ----------------------------------------------------------------
  wire [9:0] offVec = offState;

  for (genvar g = 0; g < 10; g++) begin : gGate
    pmdb_gate uGate (
      .mclk       (mclk),
      .reset_n    (reset_n),
      .offReq     (offVec[g]),
      .clkEn      (periphClkEn[g]),
      .periphRst_n(periphRst_n[g])
    );
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_OC4_WRITE: assert property (@(posedge mclk) disable iff (!reset_n)
    wrTwo |=> offState.outCompare4Off == $past(apbReq.pwdata[3]))
    else $error("oc4 disable does not follow write");
  AST_OC3_WRITE: assert property (@(posedge mclk) disable iff (!reset_n)
    wrTwo |=> offState.outCompare3Off == $past(apbReq.pwdata[2]))
    else $error("oc3 disable does not follow write");
  AST_OC2_WRITE: assert property (@(posedge mclk) disable iff (!reset_n)
    wrTwo |=> offState.outCompare2Off == $past(apbReq.pwdata[1]))
    else $error("oc2 disable does not follow write");
  AST_OC1_WRITE: assert property (@(posedge mclk) disable iff (!reset_n)
    wrTwo |=> offState.outCompare1Off == $past(apbReq.pwdata[0]))
    else $error("oc1 disable does not follow write");
  AST_TIMER_WRITE: assert property (@(posedge mclk) disable iff (!reset_n)
    wrThree |=> {offState.timerNineOff, offState.timerEightOff, offState.timerSevenOff,
                 offState.timerSixOff} == $past(apbReq.pwdata[15:12]))
    else $error("timer disables do not follow write");
  AST_UNIMP_ZERO: assert property (@(posedge mclk) disable iff (!reset_n)
    (accessPh && !apbReq.pwrite && $past(setupPh && hitThree)) |-> apbRsp.prdata[11:2] == 10'h000)
    else $error("unimplemented bits read nonzero");
  AST_IIC_WRITE: assert property (@(posedge mclk) disable iff (!reset_n)
    wrThree |=> offState.secondIicOff == $past(apbReq.pwdata[1]))
    else $error("iic disable does not follow write");
  AST_ADC_WRITE: assert property (@(posedge mclk) disable iff (!reset_n)
    wrThree |=> offState.secondAdcOff == $past(apbReq.pwdata[0]))
    else $error("adc disable does not follow write");
  AST_RESET_CLEAR: assert property (@(posedge mclk)
    !reset_n |=> (disTwo_r == 16'h0000 && disThree_r == 16'h0000))
    else $error("disable bits not cleared by reset");
  AST_READBACK: assert property (@(posedge mclk) disable iff (!reset_n)
    (setupPh && hitTwo && !apbReq.pwrite) |=> apbRsp.prdata == {16'h0000, $past(disTwo_r)})
    else $error("second register read back mismatch");
  AST_GATED: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(offState.timerSixOff) |=> !periphClkEn[5])
    else $error("timer six clock not stopped");
  // a stray write to an unmapped place must not alias onto either register
  AST_UNMAPPED_HOLD: assert property (@(posedge mclk) disable iff (!reset_n)
    (accessPh && apbReq.pwrite && !mapped) |=> ($stable(disTwo_r) && $stable(disThree_r)))
    else $error("unmapped write changed a disable register");
  AST_READBACK3: assert property (@(posedge mclk) disable iff (!reset_n)
    (setupPh && hitThree && !apbReq.pwrite) |=> apbRsp.prdata == {16'h0000, $past(disThree_r)})
    else $error("third register read back mismatch");
  AST_UPPER_ZERO: assert property (@(posedge mclk) disable iff (!reset_n)
    (accessPh && !apbReq.pwrite) |-> apbRsp.prdata[31:16] == 16'h0000)
    else $error("upper half of read data nonzero");

  COV_WR_TWO:   cover property (@(posedge mclk) disable iff (!reset_n) wrTwo);
  COV_WR_THREE: cover property (@(posedge mclk) disable iff (!reset_n) wrThree);
  COV_BAD_ADDR: cover property (@(posedge mclk) disable iff (!reset_n) apbRsp.pslverr);
  COV_ALL_OFF:  cover property (@(posedge mclk) disable iff (!reset_n) periphClkEn == 10'h000);
endmodule // pmdb_bank

// ==== tb/pmdb_bank_test.sv ====
`include "pmdb_consts.svh"

// ----------------------------------------------------------------
// compare helper
// ----------------------------------------------------------------
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin mismatches++; \
  $display("unexpected at %0t: got %0h want %0h", $time, got, exp); end end

module pmdb_bank_test;
  timeunit 1ns;
  timeprecision 1ps;
  import pmdb_pkg::*;

  logic          mclk;
  logic          reset_n;
  pmdb_apb_req_t apbReq;
  pmdb_apb_rsp_t apbRsp;
  pmdb_off_t     offState;
  logic [9:0]    periphClkEn;
  logic [9:0]    periphRst_n;
  logic [31:0]   rdData;
  logic          rdErr;
  int            mismatches;
  int            checked;
  int            cycles;
  int            bitPos [10] = '{0, 1, 2, 3, 12, 13, 14, 15, 1, 0};

  pmdb_bank dut (
    .mclk        (mclk),
    .reset_n     (reset_n),
    .apbReq      (apbReq),
    .apbRsp      (apbRsp),
    .offState    (offState),
    .periphClkEn (periphClkEn),
    .periphRst_n (periphRst_n)
  );

  // ----------------------------------------------------------------
  // clock and hang guard
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // whole run is a few hundred cycles, so 3000 means a stuck wait
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge mclk);
    apbReq.penable <= 1'b1;
    // no wait count assumed: the loop ends on pready, and only the guard ends a stuck wait
    do @(posedge mclk); while (apbRsp.pready !== 1'b1);
    rdData = apbRsp.prdata;
    rdErr = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask

  task automatic rdChk(input logic [11:0] a, input logic [31:0] exp, input logic errExp);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rdData, exp)
    `CHK(rdErr, errExp)
  endtask

  // gating lags the register by one flop, so look two edges on
  task automatic outChk(input logic [9:0] off);
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    `CHK(offState, off)
    `CHK(periphClkEn, ~off)
    `CHK(periphRst_n, ~off)
  endtask

  task automatic finish_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    apbReq = '0;
    reset_n = 1'b0;
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    outChk(10'h000);
    rdChk(`PMDB_OFF_DIS2, 32'h0000_0000, 1'b0);
    rdChk(`PMDB_OFF_DIS3, 32'h0000_0000, 1'b0);
    // one disable bit at a time, the other register cleared
    for (int i = 0; i < 10; i++) begin
      apb(1'b1, (i < 4) ? `PMDB_OFF_DIS3 : `PMDB_OFF_DIS2, 32'h0000_0000);
      apb(1'b1, (i < 4) ? `PMDB_OFF_DIS2 : `PMDB_OFF_DIS3, 32'h0000_0001 << bitPos[i]);
      outChk(10'h200 >> i);
      rdChk((i < 4) ? `PMDB_OFF_DIS2 : `PMDB_OFF_DIS3, 32'h0000_0001 << bitPos[i], 1'b0);
    end
    apb(1'b1, `PMDB_OFF_DIS3, 32'h0000_0000);
    outChk(10'h000);
    apb(1'b1, `PMDB_OFF_DIS3, 32'hFFFF_FFFF);
    rdChk(`PMDB_OFF_DIS3, 32'h0000_F003, 1'b0);
    outChk(10'h03F);
    apb(1'b1, `PMDB_OFF_DIS2, 32'hFFFF_FFFF);
    rdChk(`PMDB_OFF_DIS2, 32'h0000_FFFF, 1'b0);
    outChk(10'h3FF);
    // unmapped place must leave both registers alone
    apb(1'b1, 12'h008, 32'h0000_0000);
    `CHK(rdErr, 1'b1)
    rdChk(12'h008, 32'h0000_0000, 1'b1);
    rdChk(`PMDB_OFF_DIS3, 32'h0000_F003, 1'b0);
    rdChk(`PMDB_OFF_DIS2, 32'h0000_FFFF, 1'b0);
    // second reset in mid-run
    @(posedge mclk);
    reset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    outChk(10'h000);
    rdChk(`PMDB_OFF_DIS2, 32'h0000_0000, 1'b0);
    rdChk(`PMDB_OFF_DIS3, 32'h0000_0000, 1'b0);
    finish_test();
  end

endmodule // pmdb_bank_test
